// [verilog/pan_nextpage_regs.sv]
`timescale 1ns/1ns
`default_nettype none

module pan_nextpage_regs
    import pan_pkg::*;
#(
    parameter int NUM_PORTS    = NUM_PORTS_DEF,
    parameter int NUM_TX_PORTS = NUM_TX_PORTS_DEF
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    input  wire logic [NUM_PORTS-1:0] pd_fault_evt,
    input  wire logic [NUM_PORTS-1:0] page_rx_evt,
    input  wire logic [NUM_PORTS-1:0] partner_nextpage_able,
    input  wire logic [NUM_PORTS-1:0] partner_an_able,
    input  wire logic [NUM_PORTS-1:0] base_toggle,
    input  wire logic [NUM_PORTS-1:0] nextpage_first,
    input  wire logic [NUM_PORTS-1:0] nextpage_exchanged,
    output logic      [NUM_PORTS-1:0] more_pages_follow,
    output logic      [NUM_PORTS-1:0] message_page_flag,
    output logic      [NUM_PORTS-1:0] comply_acknowledge,
    output logic      [NUM_PORTS-1:0] toggle
);

    // ------------------------------------------------------------
    // Selection decode
    // ------------------------------------------------------------
    function automatic logic sel_hits(
        input logic [7:0] sel,
        input int         port
    );
        logic [3:0] num;
        num = sel[SEL_PORT_MSB:0];
        sel_hits = (sel[7:SEL_TABLE_LSB] == TABLE_ENERGY)
                && (num == 4'(port + 1));
    endfunction

    pan_top_state_t st;
    pan_top_state_t next_st;

    logic [15:0] status_word [NUM_PORTS];
    logic [15:0] tx_word     [NUM_PORTS];
    logic [NUM_PORTS-1:0] status_lo_rd;
    logic [NUM_PORTS-1:0] tx_hi_wr;
    logic data_rd;
    logic data_wr;

    assign data_rd = reg_rd && (reg_addr == ADDR_DATA);
    assign data_wr = reg_wr && (reg_addr == ADDR_DATA);

    // ------------------------------------------------------------
    // Per-port strobes
    // ------------------------------------------------------------
    always_comb
    begin
        status_lo_rd = '0;
        tx_hi_wr     = '0;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (data_rd && sel_hits(st.select, p) && st.offset == OFS_STATUS_LO)
            begin
                status_lo_rd[p] = 1'b1;
            end
            if (data_wr && sel_hits(st.select, p) && st.offset == OFS_TX_HI
                && p < NUM_TX_PORTS)
            begin
                tx_hi_wr[p] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Port state
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port
        pan_port #(
            .TX_PRESENT (g < NUM_TX_PORTS)
        ) u_port (
            .clk_sys            (clk_sys),
            .rst_b              (rst_b),
            .status_lo_rd       (status_lo_rd[g]),
            .tx_hi_wr           (tx_hi_wr[g]),
            .wdata              (reg_wdata),
            .pd_fault_evt       (pd_fault_evt[g]),
            .page_rx_evt        (page_rx_evt[g]),
            .partner_nextpage_able (partner_nextpage_able[g]),
            .partner_an_able    (partner_an_able[g]),
            .base_toggle        (base_toggle[g]),
            .nextpage_first     (nextpage_first[g]),
            .nextpage_exchanged (nextpage_exchanged[g]),
            .status_word        (status_word[g]),
            .tx_word            (tx_word[g]),
            .more_pages_follow  (more_pages_follow[g]),
            .message_page_flag  (message_page_flag[g]),
            .comply_acknowledge (comply_acknowledge[g]),
            .toggle             (toggle[g])
        );
    end

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        if (reg_wr)
        begin
            if (reg_addr == ADDR_SELECT)
            begin
                next_st.select = reg_wdata;
            end
            else if (reg_addr == ADDR_OFFSET)
            begin
                next_st.offset = reg_wdata;
            end
        end
        if (reg_rd)
        begin
            next_st.rdata = '0;
            if (reg_addr == ADDR_SELECT)
            begin
                next_st.rdata = st.select;
            end
            else if (reg_addr == ADDR_OFFSET)
            begin
                next_st.rdata = st.offset;
            end
            else if (reg_addr == ADDR_DATA)
            begin
                for (int p = 0; p < NUM_PORTS; p++)
                begin
                    if (sel_hits(st.select, p))
                    begin
                        if (st.offset == OFS_STATUS_HI)
                        begin
                            next_st.rdata = status_word[p][15:8];
                        end
                        else if (st.offset == OFS_STATUS_LO)
                        begin
                            next_st.rdata = status_word[p][7:0];
                        end
                        else if (st.offset == OFS_TX_HI)
                        begin
                            next_st.rdata = tx_word[p][15:8];
                        end
                        else if (st.offset == OFS_TX_LO)
                        begin
                            next_st.rdata = tx_word[p][7:0];
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;

endmodule

`default_nettype wire

// [include/pan_pkg.sv]
`default_nettype none

package pan_pkg;

    // ------------------------------------------------------------
    // Indirect access addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SELECT     = 8'h6e;
    localparam logic [7:0] ADDR_OFFSET     = 8'h6f;
    localparam logic [7:0] ADDR_DATA       = 8'ha0;
    localparam logic [2:0] TABLE_ENERGY    = 3'h1;
    localparam int         SEL_TABLE_LSB   = 5;
    localparam int         SEL_PORT_MSB    = 3;

    // ------------------------------------------------------------
    // Indirect offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS_HI   = 8'h0c;
    localparam logic [7:0] OFS_STATUS_LO   = 8'h0d;
    localparam logic [7:0] OFS_TX_HI       = 8'h0e;
    localparam logic [7:0] OFS_TX_LO       = 8'h0f;

    // ------------------------------------------------------------
    // Expansion status fields
    // ------------------------------------------------------------
    localparam int ST_LOC_ABLE      = 6;
    localparam int ST_LOC_SEL       = 5;
    localparam int ST_PD_FAULT      = 4;
    localparam int ST_PARTNER_NEXTPAGE = 3;
    localparam int ST_LOCAL_NEXTPAGE   = 2;
    localparam int ST_PAGE_RX       = 1;
    localparam int ST_PARTNER_AN    = 0;
    localparam logic ST_LOC_ABLE_VAL = 1'b1;
    localparam logic ST_LOC_SEL_VAL  = 1'b1;
    localparam logic ST_LOCAL_NEXTPAGE_VAL = 1'b1;

    // ------------------------------------------------------------
    // Next-page transmit fields, as bits of the upper byte
    // ------------------------------------------------------------
    localparam int HB_MORE_PAGES    = 7;
    localparam int HB_MESSAGE_PAGE  = 5;
    localparam int HB_COMPLY_ACK    = 4;
    localparam int HB_TOGGLE        = 3;
    localparam logic RST_MORE_PAGES   = 1'b0;
    localparam logic RST_MESSAGE_PAGE = 1'b1;
    localparam logic RST_COMPLY_ACK   = 1'b0;
    localparam logic RST_TOGGLE       = 1'b0;

    localparam int NUM_PORTS_DEF    = 4;
    localparam int NUM_TX_PORTS_DEF = 3;

    typedef struct packed {
        logic pd_fault;
        logic page_rx;
        logic partner_nextpage;
        logic partner_an;
        logic more_pages_follow;
        logic message_page_flag;
        logic comply_acknowledge;
        logic toggle;
    } pan_port_state_t;

    typedef struct packed {
        logic [7:0] select;
        logic [7:0] offset;
        logic [7:0] rdata;
    } pan_top_state_t;

endpackage

`default_nettype wire

// [verilog/pan_port.sv]
`timescale 1ns/1ns
`default_nettype none

module pan_port
    import pan_pkg::*;
#(
    parameter bit TX_PRESENT = 1'b1
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        status_lo_rd,
    input  wire logic        tx_hi_wr,
    input  wire logic [7:0]  wdata,
    input  wire logic        pd_fault_evt,
    input  wire logic        page_rx_evt,
    input  wire logic        partner_nextpage_able,
    input  wire logic        partner_an_able,
    input  wire logic        base_toggle,
    input  wire logic        nextpage_first,
    input  wire logic        nextpage_exchanged,
    output logic      [15:0] status_word,
    output logic      [15:0] tx_word,
    output logic             more_pages_follow,
    output logic             message_page_flag,
    output logic             comply_acknowledge,
    output logic             toggle
);

    pan_port_state_t st;
    pan_port_state_t next_st;

    always_comb
    begin
        next_st                  = st;
        next_st.partner_nextpage = partner_nextpage_able;
        next_st.partner_an       = partner_an_able;
        if (status_lo_rd)
        begin
            next_st.pd_fault = 1'b0;
            next_st.page_rx  = 1'b0;
        end
        if (pd_fault_evt)
        begin
            next_st.pd_fault = 1'b1;
        end
        if (page_rx_evt)
        begin
            next_st.page_rx = 1'b1;
        end
        if (TX_PRESENT && tx_hi_wr)
        begin
            next_st.more_pages_follow  = wdata[HB_MORE_PAGES];
            next_st.message_page_flag  = wdata[HB_MESSAGE_PAGE];
            next_st.comply_acknowledge = wdata[HB_COMPLY_ACK];
        end
        if (!TX_PRESENT)
        begin
            next_st.toggle = RST_TOGGLE;
        end
        else if (nextpage_first)
        begin
            next_st.toggle = ~base_toggle;
        end
        else if (nextpage_exchanged)
        begin
            next_st.toggle = ~st.toggle;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st                    <= '0;
            st.more_pages_follow  <= RST_MORE_PAGES;
            st.message_page_flag  <= TX_PRESENT ? RST_MESSAGE_PAGE : 1'b0;
            st.comply_acknowledge <= RST_COMPLY_ACK;
            st.toggle             <= RST_TOGGLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    always_comb
    begin
        status_word                      = '0;
        status_word[ST_LOC_ABLE]         = ST_LOC_ABLE_VAL;
        status_word[ST_LOC_SEL]          = ST_LOC_SEL_VAL;
        status_word[ST_PD_FAULT]         = st.pd_fault;
        status_word[ST_PARTNER_NEXTPAGE] = st.partner_nextpage;
        status_word[ST_LOCAL_NEXTPAGE]   = ST_LOCAL_NEXTPAGE_VAL;
        status_word[ST_PAGE_RX]    = st.page_rx;
        status_word[ST_PARTNER_AN] = st.partner_an;
        tx_word                    = '0;
        tx_word[8+HB_MORE_PAGES]   = st.more_pages_follow;
        tx_word[8+HB_MESSAGE_PAGE] = st.message_page_flag;
        tx_word[8+HB_COMPLY_ACK]   = st.comply_acknowledge;
        tx_word[8+HB_TOGGLE]       = st.toggle;
    end

    assign more_pages_follow  = st.more_pages_follow;
    assign message_page_flag  = st.message_page_flag;
    assign comply_acknowledge = st.comply_acknowledge;
    assign toggle             = st.toggle;

endmodule

`default_nettype wire

// [tb/pan_nextpage_regs_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module pan_chk
    import pan_pkg::*;
#(
    parameter int NUM_PORTS    = 4,
    parameter int NUM_TX_PORTS = 3
)
(
    input wire logic                 clk_sys,
    input wire logic                 rst_b,
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_wdata,
    input wire logic [7:0]           reg_rdata,
    input wire logic [NUM_PORTS-1:0] pd_fault_evt,
    input wire logic [NUM_PORTS-1:0] page_rx_evt,
    input wire logic [NUM_PORTS-1:0] partner_nextpage_able,
    input wire logic [NUM_PORTS-1:0] partner_an_able,
    input wire logic [NUM_PORTS-1:0] base_toggle,
    input wire logic [NUM_PORTS-1:0] nextpage_first,
    input wire logic [NUM_PORTS-1:0] nextpage_exchanged,
    input wire logic [NUM_PORTS-1:0] more_pages_follow,
    input wire logic [NUM_PORTS-1:0] message_page_flag,
    input wire logic [NUM_PORTS-1:0] comply_acknowledge,
    input wire logic [NUM_PORTS-1:0] toggle
);
    logic [7:0]           sel_q;
    logic [7:0]           ofs_q;
    logic [NUM_PORTS-1:0] nextpage_d;
    logic [NUM_PORTS-1:0] an_d;
    logic [1:0]           pidx;
    logic                 hit;
    logic                 lo_rd;
    logic                 tx_wr;
    logic                 ev;
    assign pidx = sel_q[1:0] - 2'h1;
    assign hit = reg_addr == ADDR_DATA && sel_q[7:5] == TABLE_ENERGY && sel_q[3:0] != 4'h0
        && sel_q[3:0] <= 4'(NUM_PORTS);
    assign lo_rd = reg_rd && hit && ofs_q == OFS_STATUS_LO;
    assign tx_wr = reg_wr && hit && ofs_q == OFS_TX_HI && sel_q[3:0] <= 4'(NUM_TX_PORTS);
    assign ev = page_rx_evt[pidx] || pd_fault_evt[pidx];
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_q <= 8'h00;
            ofs_q <= 8'h00;
            nextpage_d <= '0;
            an_d <= '0;
        end
        else
        begin
            if (reg_wr && reg_addr == ADDR_SELECT)
                sel_q <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_OFFSET)
                ofs_q <= reg_wdata;
            nextpage_d <= partner_nextpage_able;
            an_d <= partner_an_able;
        end
    end
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence s_lo_rd;
        lo_rd;
    endsequence
    // Same port as the previous cycle
    sequence s_same_rd;
        lo_rd && $stable(sel_q);
    endsequence
    sequence s_evt_rd;
        lo_rd && page_rx_evt[pidx] ##1 !lo_rd && $stable(sel_q) ##1 s_same_rd;
    endsequence
    sequence s_clean_rd;
        lo_rd && !ev ##1 !ev && $stable(sel_q) ##1 s_same_rd;
    endsequence
    status_const_a: assert property (s_lo_rd |=> reg_rdata[7:5] == 3'h3 && reg_rdata[2])
        else $error("status constant bits wrong");
    status_hi_a: assert property (reg_rd && hit && ofs_q == OFS_STATUS_HI |=>
        reg_rdata == 8'h00)
        else $error("status upper byte not zero");
    partner_bits_a: assert property (s_lo_rd |=>
        {reg_rdata[3], reg_rdata[0]} == $past({nextpage_d[pidx], an_d[pidx]}))
        else $error("partner ability bits wrong");
    set_wins_a: assert property (s_evt_rd |=> reg_rdata[1])
        else $error("page received lost on read");
    read_clear_a: assert property (s_clean_rd |=> !reg_rdata[4] && !reg_rdata[1])
        else $error("status bits not cleared by read");
    tx_write_a: assert property (tx_wr |=>
        {more_pages_follow[pidx], message_page_flag[pidx], comply_acknowledge[pidx]}
            == $past({reg_wdata[7], reg_wdata[5], reg_wdata[4]}))
        else $error("transmit fields not written");
    port4_tx_a: assert property ({more_pages_follow[NUM_PORTS-1],
        message_page_flag[NUM_PORTS-1], comply_acknowledge[NUM_PORTS-1]} == 3'h0)
        else $error("port four transmit field set");
    tgl_first_a: assert property (nextpage_first[0] |=>
        toggle[0] == !$past(base_toggle[0]))
        else $error("first toggle wrong");
    tgl_flip_a: assert property (nextpage_exchanged[0] && !nextpage_first[0] |=>
        toggle[0] != $past(toggle[0]))
        else $error("toggle did not flip");
    tgl_hold_a: assert property (!nextpage_first[0] && !nextpage_exchanged[0] |=>
        $stable(toggle[0]))
        else $error("toggle changed without exchange");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule
bind pan_nextpage_regs pan_chk #(.NUM_PORTS(NUM_PORTS), .NUM_TX_PORTS(NUM_TX_PORTS)) u_chk (
    .clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pd_fault_evt,
    .page_rx_evt, .partner_nextpage_able, .partner_an_able, .base_toggle, .nextpage_first,
    .nextpage_exchanged, .more_pages_follow, .message_page_flag, .comply_acknowledge, .toggle);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb
    import pan_pkg::*;
;
    logic       clk_sys, rst_b, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic [3:0] pd_fault_evt, page_rx_evt, partner_nextpage_able, partner_an_able, base_toggle;
    logic [3:0] nextpage_first, nextpage_exchanged, more_pages_follow, message_page_flag;
    logic [3:0] comply_acknowledge, toggle;
    int         miscompares, num_checks;
    pan_nextpage_regs u_dut (.clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .pd_fault_evt, .page_rx_evt, .partner_nextpage_able, .partner_an_able,
        .base_toggle, .nextpage_first, .nextpage_exchanged, .more_pages_follow,
        .message_page_flag, .comply_acknowledge, .toggle);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic sel(input logic [3:0] p, input logic [7:0] o);
        wr(ADDR_SELECT, {TABLE_ENERGY, 1'b0, p});
        wr(ADDR_OFFSET, o);
    endtask
    task automatic tg(input logic f, input logic x, input logic b, input logic e);
        @(posedge clk_sys);
        nextpage_first <= {3'h0, f};
        nextpage_exchanged <= {3'h0, x};
        base_toggle <= {3'h0, b};
        @(posedge clk_sys);
        nextpage_first <= 4'h0;
        nextpage_exchanged <= 4'h0;
        #1;
        chk(toggle[0], e);
    endtask
    task automatic t_reset;
        chk({message_page_flag, more_pages_follow, comply_acknowledge, toggle}, 16'h7000);
        for (int p = 1; p <= 4; p++)
        begin
            sel(4'(p), OFS_STATUS_HI);
            rd(ADDR_DATA);
            chk(rd_val, 8'h00);
            sel(4'(p), OFS_STATUS_LO);
            rd(ADDR_DATA);
            chk(rd_val, 8'h64);
            sel(4'(p), OFS_TX_HI);
            rd(ADDR_DATA);
            chk(rd_val, p < 4 ? 8'h20 : 8'h00);
        end
    endtask
    task automatic t_events;
        @(posedge clk_sys);
        pd_fault_evt <= 4'h2;
        page_rx_evt <= 4'h2;
        partner_nextpage_able <= 4'h2;
        partner_an_able <= 4'h2;
        @(posedge clk_sys);
        pd_fault_evt <= 4'h0;
        page_rx_evt <= 4'h0;
        sel(4'h2, OFS_STATUS_HI);
        rd(ADDR_DATA);
        chk(rd_val, 8'h00);
        sel(4'h2, OFS_STATUS_LO);
        rd(ADDR_DATA);
        chk(rd_val, 8'h7f);
        rd(ADDR_DATA);
        chk(rd_val, 8'h6d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        page_rx_evt <= 4'h2;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        page_rx_evt <= 4'h0;
        rd(ADDR_DATA);
        chk(rd_val, 8'h6f);
    endtask
    task automatic t_tx;
        for (int p = 1; p <= 4; p++)
        begin
            sel(4'(p), OFS_TX_HI);
            wr(ADDR_DATA, 8'hb8);
            chk({more_pages_follow[p-1], message_page_flag[p-1], comply_acknowledge[p-1],
                toggle[p-1]}, p < 4 ? 4'he : 4'h0);
            rd(ADDR_DATA);
            chk(rd_val, p < 4 ? 8'hb0 : 8'h00);
            wr(ADDR_DATA, 8'h00);
            chk({more_pages_follow[p-1], message_page_flag[p-1], comply_acknowledge[p-1]},
                3'h0);
        end
        sel(4'h1, OFS_TX_LO);
        wr(ADDR_DATA, 8'hff);
        rd(ADDR_DATA);
        chk(rd_val, 8'h00);
    endtask
    task automatic t_toggle;
        tg(1'b1, 1'b0, 1'b0, 1'b1);
        tg(1'b0, 1'b1, 1'b0, 1'b0);
        tg(1'b1, 1'b1, 1'b1, 1'b0);
        tg(1'b0, 1'b1, 1'b1, 1'b1);
        sel(4'h1, OFS_TX_HI);
        rd(ADDR_DATA);
        chk(rd_val, 8'h08);
    endtask
    task automatic t_bad;
        logic [7:0] bad [3] = '{8'h41, 8'h20, 8'h25};
        foreach (bad[i])
        begin
            sel(4'h1, OFS_STATUS_LO);
            rd(ADDR_DATA);
            wr(ADDR_SELECT, bad[i]);
            rd(ADDR_DATA);
            chk(rd_val, 8'h00);
        end
        rd(8'h55);
        chk(rd_val, 8'h00);
    endtask
    task automatic results;
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial
    begin
        #400000;
        miscompares++;
        results;
    end
    initial
    begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, pd_fault_evt, page_rx_evt} = '0;
        {partner_nextpage_able, partner_an_able, base_toggle} = '0;
        {nextpage_first, nextpage_exchanged} = '0;
        miscompares = 0;
        num_checks = 0;
        rst_b = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset;
        t_events;
        t_tx;
        t_toggle;
        t_bad;
        results;
    end
endmodule
`default_nettype wire
